// ==== design/mcu_mem_core.sv ====
`timescale 1ns/1ps

module mcu_mem_core
#(
    parameter int ROM_DEPTH = mcu_mem_pkg::ROM_WORDS
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input mcu_mem_pkg::osc_mode_t osc_mode,
    input wire logic clock_input_pin,
    input wire logic secondary_clock_pin,
    input wire logic prog_we,
    input wire logic [mcu_mem_pkg::PC_W-1:0] prog_addr,
    input wire logic [mcu_mem_pkg::INSTR_W-1:0] prog_wdata,
    output logic [mcu_mem_pkg::PC_W-1:0] pc_q,
    output logic [mcu_mem_pkg::DIGIT_W-1:0] acc_q,
    output logic [mcu_mem_pkg::DIGIT_SEL_W-1:0] d_port_q,
    output logic [mcu_mem_pkg::LATCH_W-1:0] l_port_q,
    output logic [mcu_mem_pkg::EN_W-1:0] enable_q,
    output logic illegal_instr_q,
    output logic instr_stb_q,
    output logic clk_too_fast_q
);
    import mcu_mem_pkg::*;

    // ==========================================================
    // Storage
    logic [INSTR_W-1:0] rom_mem [ROM_DEPTH];
    logic [DIGIT_W-1:0] ram_mem [RAM_REGS][RAM_DIGITS];
    logic [PC_W-1:0] return_save_first_q, return_save_second_q;
    logic [REG_SEL_W-1:0] register_select_field_q;
    logic [DIGIT_SEL_W-1:0] digit_select_field_q;
    logic [LATCH_W-1:0] latch_q;
    seq_state_t state_q;
    logic cycle_stb;
    logic [INSTR_W-1:0] instr;
    logic [PC_W-1:0] pc_next;
    logic [DIGIT_W-1:0] mem_rd, direct_rd;
    logic [DIGIT_IDX_W-1:0] ptr_idx, direct_idx;
    logic run, lookup_done;
    logic do_clear, do_exchange, do_load, do_add, do_direct, do_out_digit;
    logic do_latch_in, do_lookup, do_return, do_enable, do_comp;
    logic do_digit_imm, do_reg_imm, do_acc_imm, do_jump, do_call, do_illegal;

    // Digit index, 0-7 and 8-15 share cells
    function automatic logic [DIGIT_IDX_W-1:0] digit_index
    (
        input logic [DIGIT_SEL_W-1:0] sel
    );
        digit_index = sel[DIGIT_IDX_W-1:0];
    endfunction

    // ==========================================================
    // Instruction clock
    instr_clock_divider u_clk
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .osc_mode(osc_mode),
        .clock_input_pin(clock_input_pin),
        .secondary_clock_pin(secondary_clock_pin),
        .cycle_stb_q(cycle_stb),
        .clk_too_fast_q(clk_too_fast_q)
    );

    // ==========================================================
    // Fetch and decode
    assign instr = rom_mem[pc_q];
    assign pc_next = pc_q + 9'h001;
    assign ptr_idx = digit_index(digit_select_field_q);
    assign direct_idx = digit_index(DIRECT_DIGIT);
    assign mem_rd = ram_mem[register_select_field_q][ptr_idx];
    assign direct_rd = ram_mem[DIRECT_REG][direct_idx];
    assign run = cycle_stb && state_q == ST_EXEC;
    assign lookup_done = cycle_stb && state_q == ST_LOOKUP;
    assign do_jump = instr[7:6] == GRP_JUMP;
    assign do_call = instr[7:6] == GRP_CALL;
    assign do_digit_imm = instr[7:4] == GRP_DIGIT_IMM;
    assign do_reg_imm = instr[7:4] == GRP_REG_IMM;
    assign do_acc_imm = instr[7:4] == GRP_ACC_IMM;

    always_comb
    begin
        do_clear = 1'b0;
        do_exchange = 1'b0;
        do_load = 1'b0;
        do_add = 1'b0;
        do_direct = 1'b0;
        do_out_digit = 1'b0;
        do_latch_in = 1'b0;
        do_lookup = 1'b0;
        do_return = 1'b0;
        do_enable = 1'b0;
        do_comp = 1'b0;
        do_illegal = 1'b0;
        if (!(do_jump || do_call || do_digit_imm || do_reg_imm || do_acc_imm))
        begin
            unique case (instr)
                OP_NOP: ;
                OP_CLEAR_ACC: do_clear = 1'b1;
                OP_EXCHANGE_MEM: do_exchange = 1'b1;
                OP_LOAD_MEM: do_load = 1'b1;
                OP_ADD_MEM: do_add = 1'b1;
                OP_DIRECT_EXCHANGE: do_direct = 1'b1;
                OP_OUTPUT_DIGIT: do_out_digit = 1'b1;
                OP_LATCH_PORT_INPUT: do_latch_in = 1'b1;
                OP_TABLE_LOOKUP: do_lookup = 1'b1;
                OP_RETURN: do_return = 1'b1;
                OP_LOAD_ENABLE: do_enable = 1'b1;
                OP_COMPLEMENT: do_comp = 1'b1;
                // Removed forms act as no-ops but raise the illegal_instr_q pulse
                default: do_illegal = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // Program store load
    always_ff @(posedge clk_sys)
    begin
        if (prog_we)
        begin
            rom_mem[prog_addr] <= prog_wdata;
        end
    end

    // ==========================================================
    // Sequencer state
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= ST_EXEC;
        end
        else if (run && do_lookup)
        begin
            state_q <= ST_LOOKUP;
        end
        else if (lookup_done)
        begin
            state_q <= ST_EXEC;
        end
    end

    // ==========================================================
    // Program counter and return stack
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pc_q <= PC_RESET;
            return_save_first_q <= PC_RESET;
            return_save_second_q <= PC_RESET;
        end
        else if (lookup_done)
        begin
            pc_q <= return_save_first_q;
            return_save_first_q <= return_save_second_q;
        end
        else if (run && (do_call || do_lookup))
        begin
            return_save_second_q <= return_save_first_q;
            return_save_first_q <= pc_next;
            if (do_call)
            begin
                pc_q <= {SUB_PAGE, instr[WORD_W-1:0]};
            end
            else
            begin
                pc_q <= {pc_q[PC_W-1], acc_q, mem_rd};
            end
        end
        else if (run && do_return)
        begin
            pc_q <= return_save_first_q;
            return_save_first_q <= return_save_second_q;
        end
        else if (run && do_jump)
        begin
            pc_q <= {pc_q[PC_W-1:WORD_W], instr[WORD_W-1:0]};
        end
        else if (run)
        begin
            pc_q <= pc_next;
        end
    end

    // ==========================================================
    // Accumulator
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            acc_q <= '0;
        end
        else if (run)
        begin
            if (do_clear)
            begin
                acc_q <= '0;
            end
            else if (do_exchange || do_load)
            begin
                acc_q <= mem_rd;
            end
            else if (do_add)
            begin
                acc_q <= DIGIT_W'(acc_q + mem_rd);
            end
            else if (do_direct)
            begin
                acc_q <= direct_rd;
            end
            else if (do_latch_in)
            begin
                acc_q <= latch_q[DIGIT_W-1:0];
            end
            else if (do_comp)
            begin
                acc_q <= ~acc_q;
            end
            else if (do_acc_imm)
            begin
                acc_q <= instr[DIGIT_W-1:0];
            end
        end
    end

    // ==========================================================
    // Data store writes
    always_ff @(posedge clk_sys)
    begin
        if (run && do_exchange)
        begin
            ram_mem[register_select_field_q][ptr_idx] <= acc_q;
        end
        else if (run && do_direct)
        begin
            ram_mem[DIRECT_REG][direct_idx] <= acc_q;
        end
        else if (run && do_latch_in)
        begin
            ram_mem[register_select_field_q][ptr_idx] <=
                latch_q[LATCH_W-1:DIGIT_W];
        end
    end

    // ==========================================================
    // Data pointer
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            register_select_field_q <= '0;
            digit_select_field_q <= '0;
        end
        else if (run && do_digit_imm)
        begin
            digit_select_field_q <= instr[DIGIT_SEL_W-1:0];
        end
        else if (run && do_reg_imm)
        begin
            register_select_field_q <= instr[REG_SEL_W-1:0];
        end
    end

    // ==========================================================
    // Latch, ports and enable
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            latch_q <= '0;
        end
        else if (lookup_done)
        begin
            latch_q <= instr;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            d_port_q <= '0;
            l_port_q <= '0;
            enable_q <= '0;
        end
        else
        begin
            l_port_q <= latch_q;
            if (run && do_out_digit)
            begin
                d_port_q <= digit_select_field_q;
            end
            if (run && do_enable)
            begin
                enable_q <= acc_q & EN_KEEP_MASK;
            end
        end
    end

    // ==========================================================
    // Status pulses
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            illegal_instr_q <= 1'b0;
            instr_stb_q <= 1'b0;
        end
        else
        begin
            illegal_instr_q <= run && do_illegal;
            instr_stb_q <= cycle_stb;
        end
    end

endmodule

// ==== design/mcu_mem_pkg.sv ====
package mcu_mem_pkg;

    // ==========================================================
    // Program memory
    localparam int ROM_PAGES = 8;
    localparam int PAGE_WORDS = 64;
    localparam int ROM_WORDS = ROM_PAGES * PAGE_WORDS;
    localparam int PC_W = 9;
    localparam int PAGE_W = 3;
    localparam int WORD_W = 6;
    localparam int INSTR_W = 8;
    localparam logic [PAGE_W-1:0] SUB_PAGE = 3'h2;
    localparam logic [PC_W-1:0] PC_RESET = 9'h000;

    // ==========================================================
    // Data memory
    localparam int RAM_REGS = 4;
    localparam int RAM_DIGITS = 8;
    localparam int DIGIT_W = 4;
    localparam int REG_SEL_W = 2;
    localparam int DIGIT_SEL_W = 4;
    localparam int DIGIT_IDX_W = 3;
    localparam logic [REG_SEL_W-1:0] DIRECT_REG = 2'h3;
    localparam logic [DIGIT_SEL_W-1:0] DIRECT_DIGIT = 4'hf;
    localparam int LATCH_W = 8;
    localparam int EN_W = 4;
    localparam logic [EN_W-1:0] EN_KEEP_MASK = 4'hd;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_CLEAR_ACC = 8'h01;
    localparam logic [7:0] OP_EXCHANGE_MEM = 8'h02;
    localparam logic [7:0] OP_LOAD_MEM = 8'h03;
    localparam logic [7:0] OP_ADD_MEM = 8'h04;
    localparam logic [7:0] OP_DIRECT_EXCHANGE = 8'h05;
    localparam logic [7:0] OP_OUTPUT_DIGIT = 8'h06;
    localparam logic [7:0] OP_LATCH_PORT_INPUT = 8'h07;
    localparam logic [7:0] OP_TABLE_LOOKUP = 8'h08;
    localparam logic [7:0] OP_RETURN = 8'h09;
    localparam logic [7:0] OP_LOAD_ENABLE = 8'h0a;
    localparam logic [7:0] OP_COMPLEMENT = 8'h0b;
    localparam logic [7:0] OP_COMPLEMENT_ADD_CARRY = 8'h0c;
    localparam logic [7:0] OP_ADD_TEN = 8'h0d;
    localparam logic [7:0] OP_IMMEDIATE_PORT_OUT = 8'h0e;
    localparam logic [7:0] OP_COPY_LATCH = 8'h0f;
    localparam logic [7:0] OP_TIMER_SKIP = 8'h50;
    localparam logic [3:0] GRP_DIGIT_IMM = 4'h1;
    localparam logic [3:0] GRP_REG_IMM = 4'h2;
    localparam logic [3:0] GRP_ACC_IMM = 4'h3;
    localparam logic [3:0] GRP_DIRECT_LOAD = 4'h4;
    localparam logic [3:0] GRP_OTHER_EXCHANGE = 4'h6;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_CALL = 2'h3;

    // ==========================================================
    // Instruction clock
    typedef enum logic [1:0]
    {
        OSC_RESONATOR = 2'h0,
        OSC_EXTERNAL = 2'h1,
        OSC_RC = 2'h3,
        OSC_SYNCED = 2'h2
    } osc_mode_t;

    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] DIV_MAIN_LAST = 3'h7;
    localparam logic [DIV_W-1:0] DIV_RC_LAST = 3'h3;
    localparam int SYS_CLK_KHZ = 125000;
    localparam int CLK_IN_MAX_KHZ = 500;
    localparam int MIN_EDGE_CYCLES =
        (SYS_CLK_KHZ + CLK_IN_MAX_KHZ - 1) / CLK_IN_MAX_KHZ;
    localparam int GAP_W = 9;

    // ==========================================================
    // Sequencer
    typedef enum logic
    {
        ST_EXEC = 1'b0,
        ST_LOOKUP = 1'b1
    } seq_state_t;

endpackage

// ==== design/instr_clock_divider.sv ====
`timescale 1ns/1ps

module instr_clock_divider
(
    input wire logic clk_sys,
    input wire logic rst,
    input mcu_mem_pkg::osc_mode_t osc_mode,
    input wire logic clock_input_pin,
    input wire logic secondary_clock_pin,
    output logic cycle_stb_q,
    output logic clk_too_fast_q
);
    import mcu_mem_pkg::*;

    logic ck_prev_q;
    logic sync_prev_q;
    logic [DIV_W-1:0] div_q;
    logic [GAP_W-1:0] gap_q;
    logic ck_rise;
    logic sync_rise;
    logic [DIV_W-1:0] div_last;
    localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(MIN_EDGE_CYCLES);

    assign ck_rise = clock_input_pin & ~ck_prev_q;
    assign sync_rise = secondary_clock_pin & ~sync_prev_q;
    // Divide by 4 for RC, by 8 otherwise
    assign div_last = (osc_mode == OSC_RC) ? DIV_RC_LAST : DIV_MAIN_LAST;

    // ==========================================================
    // Edge history
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ck_prev_q <= 1'b0;
            sync_prev_q <= 1'b0;
        end
        else
        begin
            ck_prev_q <= clock_input_pin;
            sync_prev_q <= secondary_clock_pin;
        end
    end

    // ==========================================================
    // Cycle divider
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            div_q <= '0;
            cycle_stb_q <= 1'b0;
        end
        else if (osc_mode == OSC_SYNCED && sync_rise)
        begin
            div_q <= '0;
            cycle_stb_q <= 1'b0;
        end
        else if (ck_rise && div_q >= div_last)
        begin
            div_q <= '0;
            cycle_stb_q <= 1'b1;
        end
        else if (ck_rise)
        begin
            div_q <= div_q + 3'h1;
            cycle_stb_q <= 1'b0;
        end
        else
        begin
            cycle_stb_q <= 1'b0;
        end
    end

    // ==========================================================
    // Input rate check
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            gap_q <= GAP_MIN;
            clk_too_fast_q <= 1'b0;
        end
        else if (ck_rise)
        begin
            gap_q <= '0;
            if (gap_q < GAP_MIN && osc_mode != OSC_RC)
            begin
                clk_too_fast_q <= 1'b1;
            end
        end
        else if (gap_q < GAP_MIN)
        begin
            gap_q <= gap_q + 9'h001;
        end
    end

endmodule

// ==== tb/mcu_mem_checker.sv ====
`timescale 1ns/1ps

module mcu_mem_checker
#(
    parameter int ROM_DEPTH = mcu_mem_pkg::ROM_WORDS
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input mcu_mem_pkg::osc_mode_t osc_mode,
    input wire logic clock_input_pin,
    input wire logic secondary_clock_pin,
    input wire logic prog_we,
    input wire logic [mcu_mem_pkg::PC_W-1:0] prog_addr,
    input wire logic [mcu_mem_pkg::INSTR_W-1:0] prog_wdata,
    input wire logic [mcu_mem_pkg::PC_W-1:0] pc_q,
    input wire logic [mcu_mem_pkg::DIGIT_W-1:0] acc_q,
    input wire logic [mcu_mem_pkg::DIGIT_SEL_W-1:0] d_port_q,
    input wire logic [mcu_mem_pkg::LATCH_W-1:0] l_port_q,
    input wire logic [mcu_mem_pkg::EN_W-1:0] enable_q,
    input wire logic illegal_instr_q,
    input wire logic instr_stb_q,
    input wire logic clk_too_fast_q
);
    import mcu_mem_pkg::*;
    // ==========================================================
    // Edge count since last strobe
    logic pin_q;
    logic rise;
    logic [3:0] edge_cnt_q;
    logic [3:0] edge_cnt_d;
    logic [3:0] need;
    assign rise = clock_input_pin && !pin_q;
    assign need = (osc_mode == OSC_RC) ? 4'h4 : 4'h8;
    always_comb
    begin
        if (instr_stb_q)
            edge_cnt_d = {3'h0, rise};
        else if (edge_cnt_q != 4'hf)
            edge_cnt_d = edge_cnt_q + {3'h0, rise};
        else
            edge_cnt_d = edge_cnt_q;
    end
    always_ff @(posedge clk_sys)
    begin
        pin_q <= rst ? 1'b0 : clock_input_pin;
        edge_cnt_q <= rst ? 4'h0 : edge_cnt_d;
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence quiet_s;
        !instr_stb_q [*6];
    endsequence
    stb_edges_a: assert property (instr_stb_q |-> edge_cnt_q >= need)
        else $error("strobe came with too few clock edges");
    stb_spacing_a: assert property (instr_stb_q |=> quiet_s)
        else $error("strobes too close together");
    ill_stb_a: assert property (illegal_instr_q |-> instr_stb_q)
        else $error("illegal pulse without strobe");
    ill_nop_a: assert property (illegal_instr_q |-> $stable(acc_q)
        && $stable(enable_q) && pc_q == $past(pc_q) + 9'h001)
        else $error("illegal opcode did not act as nop");
    state_hold_a: assert property (!instr_stb_q |-> $stable(pc_q)
        && $stable(acc_q) && $stable(d_port_q))
        else $error("state changed without strobe");
    lport_follow_a: assert property ($changed(l_port_q) |->
        $past(instr_stb_q))
        else $error("latch copy changed off strobe");
    en_bit1_a: assert property (enable_q[1] == 1'b0)
        else $error("enable bit 1 set");
    fast_sticky_a: assert property (clk_too_fast_q |=> clk_too_fast_q)
        else $error("too fast flag cleared");
    rc_slow_a: assert property (osc_mode == OSC_RC |-> !clk_too_fast_q)
        else $error("too fast flag in rc mode");
    rst_zero_a: assert property ($fell(rst) |-> pc_q == 9'h000
        && acc_q == 4'h0 && enable_q == 4'h0)
        else $error("outputs not cleared by reset");
endmodule

bind mcu_mem_core mcu_mem_checker #(.ROM_DEPTH(ROM_DEPTH)) chk
(
    .clk_sys(clk_sys), .rst(rst), .osc_mode(osc_mode),
    .clock_input_pin(clock_input_pin),
    .secondary_clock_pin(secondary_clock_pin), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .pc_q(pc_q),
    .acc_q(acc_q), .d_port_q(d_port_q), .l_port_q(l_port_q),
    .enable_q(enable_q), .illegal_instr_q(illegal_instr_q),
    .instr_stb_q(instr_stb_q), .clk_too_fast_q(clk_too_fast_q)
);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
    import mcu_mem_pkg::*;
    // ==========================================================
    // Signals and design
    localparam int CYCLE_LIMIT = 40000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    osc_mode_t osc_mode = OSC_RC;
    logic clock_input_pin = 1'b0;
    logic secondary_clock_pin = 1'b0;
    logic prog_we = 1'b0;
    logic [8:0] prog_addr = 9'h000;
    logic [7:0] prog_wdata = 8'h00;
    logic [8:0] pc_q;
    logic [3:0] acc_q;
    logic [3:0] d_port_q;
    logic [7:0] l_port_q;
    logic [3:0] enable_q;
    logic illegal_instr_q;
    logic instr_stb_q;
    logic clk_too_fast_q;
    int failures = 0;
    int checked = 0;
    int stb_count = 0;
    int cycles = 0;
    logic ill_seen = 1'b0;
    logic [7:0] prog_q[$];

    mcu_mem_core dut
    (
        .clk_sys(clk_sys), .rst(rst), .osc_mode(osc_mode),
        .clock_input_pin(clock_input_pin),
        .secondary_clock_pin(secondary_clock_pin), .prog_we(prog_we),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata), .pc_q(pc_q),
        .acc_q(acc_q), .d_port_q(d_port_q), .l_port_q(l_port_q),
        .enable_q(enable_q), .illegal_instr_q(illegal_instr_q),
        .instr_stb_q(instr_stb_q), .clk_too_fast_q(clk_too_fast_q)
    );

    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (instr_stb_q === 1'b1)
        begin
            stb_count++;
            ill_seen = illegal_instr_q;
        end
        if (cycles == CYCLE_LIMIT)
        begin
            failures++;
            $display("unexpected at %0t: run timed out", $time);
            complete_run();
        end
    end
    // ==========================================================
    // Shared tasks
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s seen %h expected %h",
                $time, what, seen, exp);
        end
    endtask

    task complete_run;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task put(input logic [8:0] a, input logic [7:0] d);
        prog_we = 1'b1;
        prog_addr = a;
        prog_wdata = d;
        tick(1);
    endtask

    task start(input osc_mode_t m);
        rst = 1'b1;
        osc_mode = m;
        foreach (prog_q[i]) put(9'(i), prog_q[i]);
        prog_we = 1'b0;
        tick(2);
        rst = 1'b0;
    endtask

    task ck_edge(input int half);
        clock_input_pin = 1'b1;
        tick(half);
        clock_input_pin = 1'b0;
        tick(half);
    endtask

    task step;
        int n;
        n = stb_count;
        repeat (4) ck_edge(3);
        check(16'(stb_count - n), 16'h0001, "strobe count");
    endtask
    // ==========================================================
    // Scenarios
    task div_test(input osc_mode_t m, input int need);
        int n;
        prog_q = {};
        start(m);
        n = stb_count;
        repeat (need - 1) ck_edge(130);
        check(16'(stb_count - n), 16'h0000, "early strobe");
        ck_edge(130);
        check(16'(stb_count - n), 16'h0001, "last edge strobe");
        check({7'h00, pc_q}, 16'h0001, "pc after nop");
        check({15'h0000, clk_too_fast_q}, 16'h0000, "slow flagged");
        $display("divider test mode %0d done", m);
    endtask

    task sync_test;
        int n;
        prog_q = {};
        start(OSC_SYNCED);
        n = stb_count;
        repeat (4) ck_edge(130);
        secondary_clock_pin = 1'b1;
        tick(2);
        secondary_clock_pin = 1'b0;
        tick(2);
        repeat (7) ck_edge(130);
        check(16'(stb_count - n), 16'h0000, "phase not reset");
        ck_edge(130);
        check(16'(stb_count - n), 16'h0001, "no strobe");
        start(OSC_EXTERNAL);
        repeat (3) ck_edge(50);
        check({15'h0000, clk_too_fast_q}, 16'h0001, "fast missed");
        $display("sync and fast test done");
    endtask

    task data_test;
        prog_q = '{8'h21, 8'h19, 8'h35, 8'h02, 8'h11, 8'h01, 8'h03,
            8'h22, 8'h19, 8'h3a, 8'h02, 8'h21, 8'h03, 8'h22, 8'h03};
        start(OSC_RC);
        repeat (7) step();
        check({12'h000, acc_q}, 16'h0005, "digit alias");
        repeat (6) step();
        check({12'h000, acc_q}, 16'h0005, "register split");
        repeat (2) step();
        check({12'h000, acc_q}, 16'h000a, "register select");
        $display("data test done");
    endtask

    task direct_test;
        prog_q = '{8'h23, 8'h1f, 8'h36, 8'h02, 8'h20, 8'h10, 8'h39, 8'h05,
            8'h23, 8'h1f, 8'h03, 8'h06, 8'h3f, 8'h0a, 8'h40};
        start(OSC_RC);
        repeat (8) step();
        check({12'h000, acc_q}, 16'h0006, "direct swap out");
        repeat (3) step();
        check({12'h000, acc_q}, 16'h0009, "direct swap in");
        step();
        check({12'h000, d_port_q}, 16'h000f, "digit output");
        repeat (2) step();
        check({12'h000, enable_q}, 16'h000d, "enable bit 1");
        step();
        check({15'h0000, ill_seen}, 16'h0001, "direct load");
        $display("direct test done");
    endtask

    task ill_test;
        prog_q = '{8'h37, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h50, 8'h5f,
            8'h60, 8'h70};
        start(OSC_RC);
        step();
        check({15'h0000, ill_seen}, 16'h0000, "legal flagged");
        for (int i = 1; i < 9; i++)
        begin
            step();
            check({15'h0000, ill_seen}, 16'h0001, "op kept");
            check({12'h000, acc_q}, 16'h0007, "removed op acted");
        end
        check({15'h0000, clk_too_fast_q}, 16'h0000, "rc flagged");
        $display("illegal opcode test done");
    endtask

    task stack_test;
        prog_q = {};
        start(OSC_RC);
        put(9'h000, 8'hc5);
        put(9'h085, 8'hc9);
        put(9'h089, 8'h09);
        put(9'h086, 8'h09);
        prog_we = 1'b0;
        step();
        check({7'h00, pc_q}, 16'h0085, "first call");
        step();
        check({7'h00, pc_q}, 16'h0089, "second call");
        step();
        check({7'h00, pc_q}, 16'h0086, "first return");
        step();
        check({7'h00, pc_q}, 16'h0001, "second return");
        $display("stack test done");
    endtask

    task lookup_test;
        prog_q = '{8'h20, 8'h10, 8'h34, 8'h02, 8'h33, 8'h08, 8'h07, 8'h03};
        start(OSC_RC);
        put(9'h034, 8'ha7);
        prog_we = 1'b0;
        repeat (6) step();
        check({7'h00, pc_q}, 16'h0034, "lookup address");
        step();
        check({7'h00, pc_q}, 16'h0006, "lookup return");
        check({8'h00, l_port_q}, 16'h00a7, "latch value");
        step();
        check({12'h000, acc_q}, 16'h0007, "latch input");
        step();
        check({12'h000, acc_q}, 16'h000a, "latch high digit");
        $display("lookup test done");
    endtask

    task pc_test;
        prog_q = '{8'hbf};
        start(OSC_RC);
        step();
        check({7'h00, pc_q}, 16'h003f, "page jump");
        step();
        check({7'h00, pc_q}, 16'h0040, "page rollover");
        $display("pc test done");
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        tick(3);
        rst = 1'b0;
        for (int i = 0; i < ROM_WORDS; i++) put(9'(i), 8'h00);
        prog_we = 1'b0;
        div_test(OSC_RESONATOR, 8);
        div_test(OSC_EXTERNAL, 8);
        div_test(OSC_RC, 4);
        sync_test();
        pc_test();
        data_test();
        direct_test();
        ill_test();
        stack_test();
        lookup_test();
        complete_run();
    end
endmodule
